// ---- verilog/lsp_seq.sv ----
// Purpose: LED select and enable, mirror supply enable, PWM pin muxing
// Assumes: 25 MHz clk_sys_i; enable and park inputs are asynchronous pins
// Notes:   Colour code and PWM come from the display sequencer on clk_sys_i
//          Pin filter adds about four cycles to every enable change
//
// Overview of operation
// - Colour select code: none 00, red 01, green 10, blue 11
// - Master enable rises 100 ms after illumination enable and operate are both high
// - Master enable drops at once on either input low
// - Active-high mirror supply enable output
// - Supply enable high while operate input high
// - Supply enable held about 156 us (3911 cycles) after park
// - Output 2: green PWM, else general output
// - Output 3: blue PWM, else general output
// - Output 1: red PWM, else general output
// - Without power chip, PWM forced high when idle
`timescale 1ns/1ps
module lsp_seq #(
    parameter int unsigned LED_DELAY_CYCLES  = lsp_pkg::LED_ON_CYCLES,
    parameter int unsigned HOLD_CYCLES       = lsp_pkg::SUPPLY_HOLD_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    // Pins from the system
    input  wire logic       illumination_enable_in_i,
    input  wire logic       operate_park_i,
    // From the display sequencer and control processor
    input  wire logic [1:0] colour_select_code_i,
    input  wire logic       seq_running_i,
    input  wire logic       sw_led_ctrl_en_i,
    input  wire logic       power_chip_present_i,
    input  wire logic [2:0] led_pwm_i,
    input  wire logic [2:0] gp_out_i,
    // Toward LED driver and regulators
    output logic            colour_select_bit0_o,
    output logic            colour_select_bit1_o,
    output logic            led_driver_master_enable_o,
    output logic            mirror_supply_enable_o,
    output logic            gp_out1_red_pwm_o,
    output logic            gp_out2_green_pwm_o,
    output logic            gp_out3_blue_pwm_o
);
    import lsp_pkg::*;

    localparam int CW = $clog2(LED_DELAY_CYCLES + 1);
    localparam int HW = $clog2(HOLD_CYCLES + 1);

    // Zero would skip a wait; an all-ones count wraps the counter width
    if (LED_DELAY_CYCLES < 1 || CW < 1) begin : g_bad_led_delay
        $error("lsp_seq: LED_DELAY_CYCLES out of range");
    end
    if (HOLD_CYCLES < 1 || HW < 1) begin : g_bad_hold_delay
        $error("lsp_seq: HOLD_CYCLES out of range");
    end

    typedef struct packed {
        lsp_led_state_type led_state;
        logic [CW-1:0]     led_cnt;
        logic [HW-1:0]     hold_cnt;
        logic [1:0]        colour;
        logic              master_en;
        logic              supply_en;
        logic [2:0]        gp_pins;
    } lsp_state_type;

    lsp_state_type state_q;
    lsp_state_type state_d;

    // Whole-state reset image; PWM pins idle high so the LEDs stay dark
    localparam lsp_state_type RST_STATE = '{
        led_state: LSP_LED_OFF,
        led_cnt:   '0,
        hold_cnt:  '0,
        colour:    COLOUR_NONE,
        master_en: RST_MASTER_ENABLE,
        supply_en: RST_SUPPLY_ENABLE,
        gp_pins:   {3{RST_PWM_LEVEL}}
    };

    // Both delay counters compare and step through these at full width
    function automatic logic count_reached(
        input int unsigned count,
        input int unsigned limit
    );
        return count >= limit;
    endfunction : count_reached

    function automatic int unsigned count_step(
        input int unsigned count
    );
        return count + 1;
    endfunction : count_step

    // Master off, software control off or sequence stopped idles the pins
    function automatic logic pwm_idle(
        input logic master_en,
        input logic sw_en,
        input logic running
    );
        return !master_en || !sw_en || !running;
    endfunction : pwm_idle

    // Companion chip owns the pins; otherwise PWM or the idle level
    function automatic logic [2:0] pin_levels(
        input logic       chip,
        input logic       idle,
        input logic [2:0] gp,
        input logic [2:0] pwm
    );
        logic [2:0] lvl;
        if (chip) begin
            lvl = gp;
        end else if (idle) begin
            lvl = {3{RST_PWM_LEVEL}};
        end else begin
            lvl = pwm;
        end
        return lvl;
    endfunction : pin_levels

    logic led_en_lvl;
    logic operate_lvl;
    logic both_high;
    logic pwm_forced;

    lsp_pin_sync u_sync_led_en (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (illumination_enable_in_i),
        .level_o   (led_en_lvl)
    );

    lsp_pin_sync u_sync_operate (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (operate_park_i),
        .level_o   (operate_lvl)
    );

    // Master enable needs both pins; the supplies follow operate alone
    assign both_high = led_en_lvl & operate_lvl;

    always_comb begin
        state_d    = state_q;
        pwm_forced = 1'b0;

        // Colour code passes straight through, registered
        state_d.colour = colour_select_code_i;

        // Master enable sequencing
        case (state_q.led_state)
            LSP_LED_OFF: begin
                state_d.master_en = 1'b0;
                if (both_high) begin
                    state_d.led_state = LSP_LED_WAIT;
                    state_d.led_cnt   = CW'(1);
                end
            end
            LSP_LED_WAIT: begin
                if (!both_high) begin
                    // Count clears here and restarts from one on the next rise
                    state_d.led_state = LSP_LED_OFF;
                    state_d.led_cnt   = '0;
                end else if (count_reached(32'(state_q.led_cnt),
                                           LED_DELAY_CYCLES)) begin
                    state_d.led_state = LSP_LED_ON;
                    state_d.master_en = 1'b1;
                end else begin
                    state_d.led_cnt =
                        CW'(count_step(32'(state_q.led_cnt)));
                end
            end
            LSP_LED_ON: begin
                if (!both_high) begin
                    state_d.led_state = LSP_LED_OFF;
                    state_d.master_en = 1'b0;
                    state_d.led_cnt   = '0;
                end
            end
            default: begin
                state_d.led_state = LSP_LED_OFF;
                state_d.master_en = 1'b0;
                state_d.led_cnt   = '0;
            end
        endcase

        // Supply enable: on with operate, held after park
        if (operate_lvl) begin
            state_d.supply_en = 1'b1;
            state_d.hold_cnt  = '0;
        end else if (state_q.supply_en) begin
            // A return to operate during the hold restarts it
            if (count_reached(32'(state_q.hold_cnt), HOLD_CYCLES)) begin
                state_d.supply_en = 1'b0;
                state_d.hold_cnt  = '0;
            end else begin
                state_d.hold_cnt =
                    HW'(count_step(32'(state_q.hold_cnt)));
            end
        end

        // PWM pins; forced high so an idle LED driver stays dark
        pwm_forced = pwm_idle(state_q.master_en, sw_led_ctrl_en_i,
                              seq_running_i);
        state_d.gp_pins = pin_levels(power_chip_present_i, pwm_forced,
            gp_out_i, led_pwm_i);
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= RST_STATE;
        end else begin
            state_q <= state_d;
        end
    end

    assign colour_select_bit0_o       = state_q.colour[0];
    assign colour_select_bit1_o       = state_q.colour[1];
    assign led_driver_master_enable_o = state_q.master_en;
    assign mirror_supply_enable_o     = state_q.supply_en;
    assign gp_out1_red_pwm_o          = state_q.gp_pins[0];
    assign gp_out2_green_pwm_o        = state_q.gp_pins[1];
    assign gp_out3_blue_pwm_o         = state_q.gp_pins[2];
endmodule : lsp_seq

// ---- verilog/lsp_pkg.sv ----
// Purpose: Shared constants for the illumination output sequencer
// Assumes: 25 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
package lsp_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned LED_ON_DELAY_MS = 100;
    localparam int unsigned SUPPLY_HOLD_US  = 500;
    // Least times round up to whole cycles
    localparam int unsigned LED_ON_CYCLES   =
        (LED_ON_DELAY_MS * (CLK_HZ / 1000) + 0) < 1 ? 1 :
        LED_ON_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned SUPPLY_HOLD_CYCLES =
        (SUPPLY_HOLD_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned SYNC_STAGES     = 3;

    // Colour select encoding
    localparam logic [1:0] COLOUR_NONE  = 2'h0;
    localparam logic [1:0] COLOUR_RED   = 2'h1;
    localparam logic [1:0] COLOUR_GREEN = 2'h2;
    localparam logic [1:0] COLOUR_BLUE  = 2'h3;

    // Reset values of the outputs
    localparam logic RST_MASTER_ENABLE  = 1'b0;
    localparam logic RST_SUPPLY_ENABLE  = 1'b0;
    localparam logic RST_PWM_LEVEL      = 1'b1;

    typedef enum logic [1:0] {
        LSP_LED_OFF,
        LSP_LED_WAIT,
        LSP_LED_ON
    } lsp_led_state_type;
endpackage : lsp_pkg

// ---- verilog/lsp_pin_sync.sv ----
// Purpose: Three-stage input filter for a pin from outside the clock domain
// Assumes: Single clock, synchronous active-high reset
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module lsp_pin_sync (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    // Pin side
    input  wire logic pin_i,
    // Filtered level
    output logic      level_o
);
    import lsp_pkg::*;

    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } lsp_sync_type;

    lsp_sync_type state_q;
    lsp_sync_type state_d;

    always_comb begin
        state_d       = state_q;
        state_d.stage = {state_q.stage[1:0], pin_i};
        // Stage 0 is read only by stage 1
        if (state_q.stage[1] == state_q.stage[2]) begin
            state_d.level = state_q.stage[2];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign level_o = state_q.level;
endmodule : lsp_pin_sync

// ---- verification/lsp_seq_chk.sv ----
// Purpose: Port assertions for the illumination output sequencer
// Assumes: Raw pin counts lead the design by its pin filter latency
// Notes:   A few cycles of slack cover the filter
`timescale 1ns/1ps
module lsp_seq_chk #(
    parameter int unsigned LED_DELAY_CYCLES = 20,
    parameter int unsigned HOLD_CYCLES      = 10
) (
    // Clock, reset and inputs
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire logic       illumination_enable_in_i,
    input wire logic       operate_park_i,
    input wire logic [1:0] colour_select_code_i,
    input wire logic       seq_running_i,
    input wire logic       sw_led_ctrl_en_i,
    input wire logic       power_chip_present_i,
    input wire logic [2:0] led_pwm_i,
    input wire logic [2:0] gp_out_i,
    // Outputs
    input wire logic       colour_select_bit0_o,
    input wire logic       colour_select_bit1_o,
    input wire logic       led_driver_master_enable_o,
    input wire logic       mirror_supply_enable_o,
    input wire logic       gp_out1_red_pwm_o,
    input wire logic       gp_out2_green_pwm_o,
    input wire logic       gp_out3_blue_pwm_o
);
    logic [31:0] on_q, park_q;
    wire  [2:0]  gp = {gp_out3_blue_pwm_o, gp_out2_green_pwm_o,
                       gp_out1_red_pwm_o};
    wire         me = led_driver_master_enable_o;
    wire         sup = mirror_supply_enable_o;
    wire         both = illumination_enable_in_i && operate_park_i;
    wire         chip = power_chip_present_i;
    // Raw-pin run lengths; the design lags them, never leads
    always_ff @(posedge clk_sys_i) begin
        on_q   <= (sys_rst_i || !both) ? 32'h0 : on_q + 32'h1;
        park_q <= (sys_rst_i || operate_park_i) ? 32'h0 : park_q + 32'h1;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_lit;
        (!chip && sw_led_ctrl_en_i && seq_running_i && me) ##1 me;
    endsequence
    property p_colour;
        !$past(sys_rst_i) |-> {colour_select_bit1_o, colour_select_bit0_o}
            == $past(colour_select_code_i);
    endproperty
    a_colour: assert property (p_colour) else $error("colour late");
    property p_rise;
        $rose(me) |-> on_q >= LED_DELAY_CYCLES;
    endproperty
    a_rise: assert property (p_rise) else $error("too early");
    property p_drop;
        !both |-> ##[0:6] !me;
    endproperty
    a_drop: assert property (p_drop) else $error("enable stuck");
    property p_needs;
        me |-> sup;
    endproperty
    a_needs: assert property (p_needs) else $error("no supply");
    property p_sup_on;
        operate_park_i [*8] |-> sup;
    endproperty
    a_sup_on: assert property (p_sup_on) else $error("supply off");
    property p_hold;
        $fell(sup) |-> park_q >= HOLD_CYCLES;
    endproperty
    a_hold: assert property (p_hold) else $error("supply short");
    property p_off;
        park_q >= HOLD_CYCLES + 8 |-> !sup;
    endproperty
    a_off: assert property (p_off) else $error("supply long");
    property p_forced;
        !chip && !(sw_led_ctrl_en_i && seq_running_i && me) |=> gp == 3'h7;
    endproperty
    a_forced: assert property (p_forced) else $error("pwm not high");
    property p_pass;
        s_lit |-> gp == $past(led_pwm_i);
    endproperty
    a_pass: assert property (p_pass) else $error("pwm");
    property p_chip;
        chip |=> gp == $past(gp_out_i);
    endproperty
    a_chip: assert property (p_chip) else $error("gpo");
endmodule : lsp_seq_chk
bind lsp_seq lsp_seq_chk #(.LED_DELAY_CYCLES(LED_DELAY_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)) chk_u (.*);

// ---- verification/lsp_led_model.sv ----
// Purpose: LED driver and mirror regulator stand-in
// Assumes: Colour decoded only while the driver is enabled
// Notes:   Supplies follow their enable with no ramp
`timescale 1ns/1ps
module lsp_led_model (
    // From the sequencer outputs
    input  wire logic [1:0] code_i,
    input  wire logic       master_en_i,
    input  wire logic       supply_en_i,
    // Lit colour and supply state
    output logic      [2:0] lit_o,
    output logic            supplies_up_o
);
    assign lit_o = master_en_i ? 3'((4'h1 << code_i) >> 1) : 3'h0;
    assign supplies_up_o = supply_en_i;
endmodule : lsp_led_model

// ---- verification/tb_lsp_seq.sv ----
// Purpose: Self-checking bench for lsp_seq
// Assumes: Short delay parameters; inputs move 1 ns after clk rises
// Notes:   Expected timing is reckoned from pin changes
`timescale 1ns/1ps
module tb_lsp_seq;
    localparam int unsigned DLY = 20;
    localparam int unsigned HLD = 10;
    logic       clk = 1'b0, rst = 1'b1, ill = 1'b0, op = 1'b0;
    logic       seq = 1'b0, sw = 1'b0, chip = 1'b0, b0, b1, me, sup, up;
    logic [1:0] code = 2'h0;
    logic [2:0] pwm = 3'h0, gpo = 3'h0, gp, lit;
    int         errors = 0, num_checks = 0, n;
    lsp_seq #(.LED_DELAY_CYCLES(DLY), .HOLD_CYCLES(HLD)) dut_u (
        .clk_sys_i(clk), .sys_rst_i(rst), .illumination_enable_in_i(ill),
        .operate_park_i(op), .colour_select_code_i(code),
        .seq_running_i(seq), .sw_led_ctrl_en_i(sw),
        .power_chip_present_i(chip), .led_pwm_i(pwm), .gp_out_i(gpo),
        .colour_select_bit0_o(b0), .colour_select_bit1_o(b1),
        .led_driver_master_enable_o(me), .mirror_supply_enable_o(sup),
        .gp_out1_red_pwm_o(gp[0]), .gp_out2_green_pwm_o(gp[1]),
        .gp_out3_blue_pwm_o(gp[2]));
    lsp_led_model led_u (.code_i({b1, b0}), .master_en_i(me),
        .supply_en_i(sup), .lit_o(lit), .supplies_up_o(up));
    initial forever #20 clk = ~clk;
    task cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task wait_me(input logic lvl);
        n = 0;
        while (me !== lvl && n < 200) begin
            cyc(1);
            n++;
        end
    endtask : wait_me
    task close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task t_reset;
        rst = 1'b1;
        code = 2'h0;
        cyc(4);
        rst = 1'b0;
        cyc(1);
        chk("reset", {b1, b0, me, sup, gp}, 7'h07);
    endtask : t_reset
    task t_enable;
        ill = 1'b1;
        op = 1'b1;
        wait_me(1'b1);
        chk("rise", n >= DLY && n <= DLY + 8, 1);
        chk("supply", {sup, up}, 2'h3);
    endtask : t_enable
    task t_colour;
        for (int c = 0; c < 4; c++) begin
            code = c[1:0];
            cyc(2);
            chk("colour", {b1, b0}, c);
            chk("lit", lit, (c == 0) ? 0 : 1 << (c - 1));
        end
    endtask : t_colour
    task t_pwm;
        {sw, seq, pwm} = 5'h1D;
        cyc(2);
        chk("pwm", gp, 3'h5);
        pwm = 3'h2;
        cyc(2);
        chk("pwm", gp, 3'h2);
        sw = 1'b0;
        cyc(2);
        chk("sw_off", gp, 3'h7);
        {sw, seq} = 2'h2;
        cyc(2);
        chk("seq_off", gp, 3'h7);
        {seq, chip, gpo} = 5'h1E;
        cyc(2);
        chk("gpo", gp, 3'h6);
        chip = 1'b0;
    endtask : t_pwm
    task t_drop;
        wait_me(1'b1);
        ill = 1'b0;
        wait_me(1'b0);
        chk("fall", n <= 6, 1);
        ill = 1'b1;
        cyc(DLY / 2);
        ill = 1'b0;
        cyc(8);
        ill = 1'b1;
        wait_me(1'b1);
        chk("restart", n >= DLY && n <= DLY + 8, 1);
        op = 1'b0;
        cyc(6);
        chk("park_fall", me, 1'b0);
        n = 6;
        while (sup === 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk("hold", n >= HLD && n <= HLD + 8, 1);
    endtask : t_drop
    initial begin
        #(40 * 3000);
        errors++;
        close_out;
    end
    initial begin
        t_reset;
        t_enable;
        t_colour;
        t_pwm;
        t_reset;
        t_drop;
        close_out;
    end
endmodule : tb_lsp_seq
